// ===== logic/data_memory_map_decoder.sv
// Data-space address decoder with external access stretching and pointer updates.
// Function
// - Normal mode: 32 registers, 64 I/O, 160 extended I/O, 4096 SRAM.
// - Compat mode: 32 registers, 64 I/O, 4000 SRAM, internal top 4096.
// - Compat mode has no extended I/O; SRAM follows standard I/O.
// - Extended I/O only via data loads/stores, never short I/O instructions.
// - External SRAM starts just above internal region, up to 64K.
// - Addresses above internal space go to external SRAM, same operations.
// - Internal accesses keep external read and write strobes inactive.
// - External accesses happen only when external memory enable is set.
// - Zero wait-states: external byte takes one extra cycle.
// - Stack external: calls, returns, interrupts take three extra cycles.
// - One to three wait-states add two to four cycles per byte.
// - Wait-states with external stack add five, seven or nine cycles.
// - Internal SRAM access completes within two clock cycles.
// - Displacement address is Y or Z plus unsigned offset up to 63; the decoder also applies the offset to X.
// - Pre-decrement before access, post-increment after access, on X, Y, Z.
// - Direct addressing reaches the whole data space.
`timescale 1ns/100ps
`include "data_map_params.svh"

module data_memory_map_decoder #(
  parameter int ADDR_W = 16
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  compat_mode,
  input  wire logic                  external_memory_enable,
  input  wire logic [1:0]            wait_states,
  input  wire logic                  req_valid,
  input  wire data_map_pkg::req_s    req,
  input  wire data_map_pkg::ptrs_s   ptrs_in,
  output logic                       busy,
  output logic                       done,
  output data_map_pkg::target_e      target_q,
  output logic [ADDR_W-1:0]          addr_q,
  output data_map_pkg::ptrs_s        ptrs_q,
  output logic                       ptr_wr_q,
  output logic [3:0]                 extra_cycles_q,
  output logic                       ext_strobe_pin_a,
  output logic                       ext_strobe_pin_b
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W != 16) begin : g_bad_width
    $error("The data space decoder serves only a 16-bit address.");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Top of the internal region, exclusive, for the selected mode.
  function automatic logic [16:0] internal_top(input logic compat);
    if (compat) begin
      internal_top = `REGFILE_SIZE + `STD_IO_SIZE + `SRAM_SIZE_COMPAT;
    end else begin
      internal_top = `REGFILE_SIZE + `STD_IO_SIZE + `EXT_IO_SIZE
                     + `SRAM_SIZE_NORMAL;
    end
  endfunction

  // Map one data address to its target.
  function automatic data_map_pkg::target_e decode(input logic [15:0] a,
                                                   input logic        compat,
                                                   input logic        short_io,
                                                   input logic        xmem_en);
    logic [16:0] aw;
    aw = {1'b0, a};
    if (short_io) begin
      // Short I/O opcodes carry six bits, so only standard I/O is reachable.
      decode = data_map_pkg::TGT_STD_IO;
    end else if (aw < `REGFILE_SIZE) begin
      decode = data_map_pkg::TGT_REGFILE;
    end else if (aw < `REGFILE_SIZE + `STD_IO_SIZE) begin
      decode = data_map_pkg::TGT_STD_IO;
    end else if (!compat && aw < `REGFILE_SIZE + `STD_IO_SIZE + `EXT_IO_SIZE) begin
      decode = data_map_pkg::TGT_EXT_IO;
    end else if (aw < internal_top(compat)) begin
      decode = data_map_pkg::TGT_INT_SRAM;
    end else if (xmem_en) begin
      decode = data_map_pkg::TGT_EXT_SRAM;
    end else begin
      decode = data_map_pkg::TGT_NONE;
    end
  endfunction

  // Extra cycles for an external access given wait-states and access kind.
  function automatic logic [3:0] ext_extra(input logic [1:0]             ws,
                                           input data_map_pkg::op_kind_e k);
    logic [3:0] w;
    w = {2'b00, ws};
    if (k == data_map_pkg::OP_PC_STACK) begin
      ext_extra = `STACK_EXTRA_BASE + (w << 1);
    end else if (ws == 2'h0) begin
      ext_extra = 4'h1;
    end else begin
      ext_extra = w + 4'h1;
    end
  endfunction

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  logic [15:0] base;
  logic [15:0] eff_addr;
  logic [15:0] ptr_new;
  logic        ptr_upd;

  // Picks the pointer, applies displacement or pre-decrement, forms post-increment.
  always_comb begin
    case (req.ptr)
      data_map_pkg::PTR_X: base = ptrs_in.x;
      data_map_pkg::PTR_Y: base = ptrs_in.y;
      default:             base = ptrs_in.z;
    endcase
    eff_addr = base;
    ptr_new  = base;
    ptr_upd  = 1'b0;
    case (req.mode)
      data_map_pkg::MODE_DIRECT: begin
        eff_addr = req.direct_addr;
      end
      data_map_pkg::MODE_DISP: begin
        eff_addr = base + {10'h000, req.disp & `DISP_MAX};
      end
      data_map_pkg::MODE_PREDEC: begin
        eff_addr = base - 16'h0001;
        ptr_new  = base - 16'h0001;
        ptr_upd  = 1'b1;
      end
      data_map_pkg::MODE_POSTINC: begin
        ptr_new  = base + 16'h0001;
        ptr_upd  = 1'b1;
      end
      default: begin
        eff_addr = base;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INT,
    ST_EXT
  } state_e;

  state_e                 state_q, state_d;
  data_map_pkg::target_e  target_d;
  logic [15:0]            addr_d;
  data_map_pkg::ptrs_s    ptrs_d;
  logic                   ptr_wr_d;
  logic [3:0]             extra_d;
  logic [3:0]             cnt_q, cnt_d;
  logic                   write_q, write_d;
  logic                   done_q, done_d;
  data_map_pkg::target_e  tgt_now;

  assign tgt_now = decode(eff_addr, compat_mode, req.short_io, external_memory_enable);

  // Next-state logic for accepting and timing one access.
  always_comb begin
    state_d  = state_q;
    target_d = target_q;
    addr_d   = addr_q;
    ptrs_d   = ptrs_q;
    ptr_wr_d = 1'b0;
    extra_d  = extra_cycles_q;
    cnt_d    = cnt_q;
    write_d  = write_q;
    done_d   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          target_d = tgt_now;
          addr_d   = eff_addr;
          write_d  = req.write;
          ptrs_d   = ptrs_in;
          if (ptr_upd) begin
            ptr_wr_d = 1'b1;
            case (req.ptr)
              data_map_pkg::PTR_X: ptrs_d.x = ptr_new;
              data_map_pkg::PTR_Y: ptrs_d.y = ptr_new;
              default:             ptrs_d.z = ptr_new;
            endcase
          end
          if (tgt_now == data_map_pkg::TGT_EXT_SRAM) begin
            extra_d = ext_extra(wait_states, req.kind);
            cnt_d   = ext_extra(wait_states, req.kind);
            state_d = ST_EXT;
          end else begin
            extra_d = 4'h0;
            cnt_d   = 4'h0;
            state_d = ST_INT;
          end
        end
      end
      ST_INT: begin
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      ST_EXT: begin
        if (cnt_q == 4'h0) begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Registers the sequencer state.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q        <= ST_IDLE;
      target_q       <= data_map_pkg::TGT_NONE;
      addr_q         <= 16'h0000;
      ptrs_q         <= '0;
      ptr_wr_q       <= 1'b0;
      extra_cycles_q <= 4'h0;
      cnt_q          <= 4'h0;
      write_q        <= 1'b0;
      done_q         <= 1'b0;
    end else begin
      state_q        <= state_d;
      target_q       <= target_d;
      addr_q         <= addr_d;
      ptrs_q         <= ptrs_d;
      ptr_wr_q       <= ptr_wr_d;
      extra_cycles_q <= extra_d;
      cnt_q          <= cnt_d;
      write_q        <= write_d;
      done_q         <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Strobes assert only during an external access; pin a writes, pin b reads.
  assign ext_strobe_pin_a = (state_q == ST_EXT) && write_q && external_memory_enable;
  assign ext_strobe_pin_b = (state_q == ST_EXT) && !write_q && external_memory_enable;
  assign busy = (state_q != ST_IDLE);
  assign done = done_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic int_acc;
  assign int_acc = (state_q == ST_INT);

  // Strobes stay low whenever the recorded target is not external memory.
  chk_int_strobes_quiet: assert property (@(posedge clk) disable iff (rst)
    (int_acc || target_q != data_map_pkg::TGT_EXT_SRAM)
      |-> !ext_strobe_pin_a && !ext_strobe_pin_b)
    else $error("External strobe active during internal access.");

  chk_int_two_cycles: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && tgt_now != data_map_pkg::TGT_EXT_SRAM)
      |=> ##1 done)
    else $error("Internal access did not finish in two cycles.");

  chk_ext_zero_wait: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && tgt_now == data_map_pkg::TGT_EXT_SRAM
     && wait_states == 2'h0 && req.kind != data_map_pkg::OP_PC_STACK)
      |=> !done ##1 !done ##1 done)
    else $error("Zero-wait external access not one cycle longer.");

  chk_ext_wait_extra: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && tgt_now == data_map_pkg::TGT_EXT_SRAM
     && wait_states != 2'h0 && req.kind != data_map_pkg::OP_PC_STACK)
      |=> extra_cycles_q == {2'b00, $past(wait_states)} + 4'h1)
    else $error("Wait-stated external extra count wrong.");

  chk_stack_extra: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && tgt_now == data_map_pkg::TGT_EXT_SRAM
     && req.kind == data_map_pkg::OP_PC_STACK)
      |=> extra_cycles_q == 4'h3 + {1'b0, $past(wait_states), 1'b0})
    else $error("External stack extra count wrong.");

  // An access taken with external memory disabled never becomes an external one.
  chk_ext_needs_enable: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && !external_memory_enable)
      |=> target_q != data_map_pkg::TGT_EXT_SRAM && !ext_strobe_pin_a && !ext_strobe_pin_b)
    else $error("External access started without external memory enable.");

  chk_map_regions: assert property (@(posedge clk) disable iff (rst)
    (req_valid && !req.short_io
     && {1'b0, eff_addr} >= `REGFILE_SIZE + `STD_IO_SIZE
     && {1'b0, eff_addr} < `REGFILE_SIZE + `STD_IO_SIZE + `EXT_IO_SIZE)
      |-> (tgt_now == (compat_mode ? data_map_pkg::TGT_INT_SRAM
                                   : data_map_pkg::TGT_EXT_IO)))
    else $error("Extended I/O window mapped wrongly for mode.");

  chk_ext_region_start: assert property (@(posedge clk) disable iff (rst)
    (req_valid && !req.short_io && external_memory_enable
     && {1'b0, eff_addr} >= (compat_mode ? `REGFILE_SIZE + `STD_IO_SIZE + `SRAM_SIZE_COMPAT
                                         : `REGFILE_SIZE + `STD_IO_SIZE + `EXT_IO_SIZE
                                           + `SRAM_SIZE_NORMAL))
      |-> tgt_now == data_map_pkg::TGT_EXT_SRAM)
    else $error("Address above internal space not routed externally.");

  chk_short_io_only: assert property (@(posedge clk) disable iff (rst)
    (req_valid && req.short_io) |-> tgt_now == data_map_pkg::TGT_STD_IO)
    else $error("Short I/O reached beyond standard I/O.");

  chk_postinc_ptr: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && req.mode == data_map_pkg::MODE_POSTINC
     && req.ptr == data_map_pkg::PTR_X)
      |=> ptr_wr_q && ptrs_q.x == $past(ptrs_in.x) + 16'h0001
          && addr_q == $past(ptrs_in.x))
    else $error("Post-increment pointer or address wrong.");

  chk_disp_addr: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && req.mode == data_map_pkg::MODE_DISP
     && req.ptr == data_map_pkg::PTR_Y)
      |=> addr_q == $past(ptrs_in.y) + {10'h000, $past(req.disp)})
    else $error("Displacement address wrong.");

  // Pre-decrement accesses at the lowered pointer and writes that pointer back.
  chk_predec_ptr: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && req.mode == data_map_pkg::MODE_PREDEC
     && req.ptr == data_map_pkg::PTR_Z)
      |=> ptr_wr_q && ptrs_q.z == $past(ptrs_in.z) - 16'h0001
          && addr_q == $past(ptrs_in.z) - 16'h0001)
    else $error("Pre-decrement pointer or address wrong.");

  // Direct addressing passes the full 16-bit address through unchanged.
  chk_direct_addr: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && req_valid && req.mode == data_map_pkg::MODE_DIRECT)
      |=> addr_q == $past(req.direct_addr))
    else $error("Direct address not passed through.");

  cov_int_access: cover property (@(posedge clk) disable iff (rst) int_acc ##1 done);
  cov_ext_read: cover property (@(posedge clk) disable iff (rst) ext_strobe_pin_b ##1 done);
  cov_ext_stack_ws3: cover property (@(posedge clk) disable iff (rst)
    extra_cycles_q == 4'h9 && ext_strobe_pin_a);
  cov_compat_sram: cover property (@(posedge clk) disable iff (rst)
    compat_mode && target_q == data_map_pkg::TGT_INT_SRAM && done);

endmodule

// ===== logic/data_map_params.svh
// Constants for the data-space address decoder and access timing.
`ifndef DATA_MAP_PARAMS_SVH
`define DATA_MAP_PARAMS_SVH
`define REGFILE_SIZE      17'h00020
`define STD_IO_SIZE       17'h00040
`define EXT_IO_SIZE       17'h000A0
`define SRAM_SIZE_NORMAL  17'h01000
`define SRAM_SIZE_COMPAT  17'h00FA0
`define SPACE_SIZE        17'h10000
`define DISP_MAX          6'h3F
`define INT_ACCESS_CYC    3'h2
`define STACK_EXTRA_BASE  4'h3
`define WAIT_MAX          2'h3
`endif

// ===== logic/data_map_pkg.sv
// Types shared by the data-space address decoder.
package data_map_pkg;
  typedef enum logic [2:0] {
    TGT_REGFILE,
    TGT_STD_IO,
    TGT_EXT_IO,
    TGT_INT_SRAM,
    TGT_EXT_SRAM,
    TGT_NONE
  } target_e;

  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_DISP,
    MODE_INDIRECT,
    MODE_PREDEC,
    MODE_POSTINC
  } addr_mode_e;

  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } ptr_sel_e;

  typedef enum logic [1:0] {
    OP_DATA,
    OP_STACK_BYTE,
    OP_PC_STACK
  } op_kind_e;

  typedef struct packed {
    logic       write;
    logic       short_io;
    op_kind_e   kind;
    addr_mode_e mode;
    ptr_sel_e   ptr;
    logic [5:0] disp;
    logic [15:0] direct_addr;
  } req_s;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } ptrs_s;
endpackage

// ===== tb/ext_sram_model.sv
// External asynchronous SRAM model that tallies strobe cycles and stray strobes.
`timescale 1ns/100ps

module ext_sram_model (
  input  wire logic        clk,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  input  wire logic [15:0] addr,
  output int               wr_total,
  output int               rd_total,
  output int               stray_total
);
  int wr_cnt    = 0;
  int rd_cnt    = 0;
  int stray_cnt = 0;

  // ------------------------------------------------------------
  // Strobe tally
  // ------------------------------------------------------------
  // Each cycle with a strobe held counts once, so the bench can see access length.
  assign wr_total    = wr_cnt;
  assign rd_total    = rd_cnt;
  assign stray_total = stray_cnt;

  // A strobe on an address below the lowest possible external location is stray.
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
    end
    if (rd_strobe === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
    if ((wr_strobe === 1'b1 || rd_strobe === 1'b1) && addr < 16'h1000) begin
      stray_cnt <= stray_cnt + 1;
    end
  end
endmodule

// ===== tb/data_memory_map_decoder_tb_top.sv
// Self-checking bench for the data-space decoder against a reference model.
`timescale 1ns/100ps

module data_memory_map_decoder_tb_top;
  logic                    clk;
  logic                    rst;
  logic                    compat_mode;
  logic                    external_memory_enable;
  logic [1:0]              wait_states;
  logic                    req_valid;
  data_map_pkg::req_s      req;
  data_map_pkg::ptrs_s     ptrs_in;
  logic                    busy;
  logic                    done;
  data_map_pkg::target_e   target_q;
  logic [15:0]             addr_q;
  data_map_pkg::ptrs_s     ptrs_q;
  logic                    ptr_wr_q;
  logic [3:0]              extra_cycles_q;
  logic                    ext_strobe_pin_a;
  logic                    ext_strobe_pin_b;
  int                      wr_total;
  int                      rd_total;
  int                      stray_total;
  int                      error_cnt;
  int                      total_checks;
  int                      seed;
  logic [15:0]             bnd [11];

  data_memory_map_decoder dut_u (
    .clk                    (clk),
    .rst                    (rst),
    .compat_mode            (compat_mode),
    .external_memory_enable (external_memory_enable),
    .wait_states            (wait_states),
    .req_valid              (req_valid),
    .req                    (req),
    .ptrs_in                (ptrs_in),
    .busy                   (busy),
    .done                   (done),
    .target_q               (target_q),
    .addr_q                 (addr_q),
    .ptrs_q                 (ptrs_q),
    .ptr_wr_q               (ptr_wr_q),
    .extra_cycles_q         (extra_cycles_q),
    .ext_strobe_pin_a       (ext_strobe_pin_a),
    .ext_strobe_pin_b       (ext_strobe_pin_b)
  );

  ext_sram_model sram_u (
    .clk         (clk),
    .wr_strobe   (ext_strobe_pin_a),
    .rd_strobe   (ext_strobe_pin_b),
    .addr        (addr_q),
    .wr_total    (wr_total),
    .rd_total    (rd_total),
    .stray_total (stray_total)
  );

  // ------------------------------------------------------------
  // Clock, comparison and verdict
  // ------------------------------------------------------------
  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  // Maps an address to its target for the current layout and enable.
  function automatic data_map_pkg::target_e exp_tgt(int a, logic cm, logic en);
    if (a < 32) return data_map_pkg::TGT_REGFILE;
    if (a < 96) return data_map_pkg::TGT_STD_IO;
    if (cm !== 1'b1 && a < 256) return data_map_pkg::TGT_EXT_IO;
    if (a < (cm === 1'b1 ? 4096 : 4352)) return data_map_pkg::TGT_INT_SRAM;
    return en === 1'b1 ? data_map_pkg::TGT_EXT_SRAM : data_map_pkg::TGT_NONE;
  endfunction

  // Issues one request, waits for done and compares every result.
  task automatic run_req(input data_map_pkg::req_s rq, input data_map_pkg::ptrs_s pi);
    logic [15:0]           p [3];
    logic [15:0]           ea;
    data_map_pkg::target_e t;
    logic                  pw;
    logic                  pw_seen;
    int                    ext;
    int                    cyc;
    int                    wr0;
    int                    rd0;
    int                    st0;
    p[0] = pi.x;
    p[1] = pi.y;
    p[2] = pi.z;
    pw = 1'b0;
    case (rq.mode)
      data_map_pkg::MODE_DIRECT: ea = rq.direct_addr;
      data_map_pkg::MODE_DISP: ea = p[rq.ptr] + 16'(rq.disp);
      data_map_pkg::MODE_PREDEC: begin
        ea = p[rq.ptr] - 16'h0001;
        p[rq.ptr] = ea;
        pw = 1'b1;
      end
      data_map_pkg::MODE_POSTINC: begin
        ea = p[rq.ptr];
        p[rq.ptr] = ea + 16'h0001;
        pw = 1'b1;
      end
      default: ea = p[rq.ptr];
    endcase
    t = rq.short_io ? data_map_pkg::TGT_STD_IO : exp_tgt(int'(ea), compat_mode,
                                                        external_memory_enable);
    ext = 0;
    if (t == data_map_pkg::TGT_EXT_SRAM) begin
      ext = (rq.kind == data_map_pkg::OP_PC_STACK) ? 3 + 2 * wait_states : wait_states + 1;
    end
    req_valid = 1'b1;
    req = rq;
    ptrs_in = pi;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    chk("busy after take", 48'h1, 48'(busy));
    wr0 = wr_total;
    rd0 = rd_total;
    st0 = stray_total;
    cyc = 1;
    pw_seen = 1'b0;
    while (cyc < 20) begin
      if (ptr_wr_q === 1'b1) pw_seen = 1'b1;
      if (done === 1'b1) break;
      @(posedge clk);
      #1;
      cyc++;
    end
    chk("busy at done", 48'h0, 48'(busy));
    chk("target", 48'(t), 48'(target_q));
    chk("address", 48'(ea), 48'(addr_q));
    chk("extra", 48'(ext), 48'(extra_cycles_q));
    chk("latency", 48'(2 + ext), 48'(cyc));
    chk("pointers", {p[0], p[1], p[2]}, ptrs_q);
    chk("pointer write", 48'(pw), 48'(pw_seen));
    chk("write strobe", 48'((ext > 0 && rq.write) ? ext + 1 : 0), 48'(wr_total - wr0));
    chk("read strobe", 48'((ext > 0 && !rq.write) ? ext + 1 : 0), 48'(rd_total - rd0));
    chk("stray strobe", 48'h0, 48'(stray_total - st0));
  endtask

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  // Boundary sweep in both layouts, then randomised traffic back to back.
  initial begin
    data_map_pkg::req_s rq;
    data_map_pkg::ptrs_s pi;
    logic [31:0]        tmp;
    seed = 29228;
    clk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    ptrs_in = '0;
    compat_mode = 1'b0;
    external_memory_enable = 1'b1;
    wait_states = 2'h0;
    error_cnt = 0;
    total_checks = 0;
    bnd = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100, 16'h0FFF,
            16'h1000, 16'h10FF, 16'h1100, 16'hFFFF};
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int m = 0; m < 2; m++) begin
      foreach (bnd[i]) begin
        for (int w = 0; w < 4; w++) begin
          compat_mode = m[0];
          wait_states = w[1:0];
          rq = '0;
          rq.direct_addr = bnd[i];
          rq.write = i[0];
          rq.kind = data_map_pkg::op_kind_e'(w % 3);
          run_req(rq, '0);
        end
      end
    end
    // A reset in mid-run must return every registered output to its idle value.
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("reset target", 48'(data_map_pkg::TGT_NONE), 48'(target_q));
    chk("reset extra", 48'h0, 48'(extra_cycles_q));
    chk("reset strobes", 48'h0, 48'({ext_strobe_pin_a, ext_strobe_pin_b}));
    chk("reset flags", 48'h0, 48'({busy, done, ptr_wr_q}));
    chk("reset pointers", 48'h0, ptrs_q);
    chk("reset address", 48'h0, 48'(addr_q));
    rst = 1'b0;
    repeat (300) begin
      tmp = $random(seed);
      compat_mode = tmp[12];
      external_memory_enable = tmp[13] | tmp[16];
      wait_states = tmp[15:14];
      rq = data_map_pkg::req_s'(31'($random(seed)));
      rq.kind = data_map_pkg::op_kind_e'(tmp[7:0] % 3);
      rq.mode = data_map_pkg::addr_mode_e'(tmp[23:17] % 5);
      rq.ptr = data_map_pkg::ptr_sel_e'(tmp[31:24] % 3);
      rq.short_io = (tmp[10:8] == 3'h0);
      pi = data_map_pkg::ptrs_s'(48'({$random(seed), $random(seed)}));
      run_req(rq, pi);
    end
    final_report();
  end

  // Cuts a hang short after far more cycles than the sequence needs.
  initial begin
    #(50 * 20000);
    error_cnt++;
    final_report();
  end
endmodule
